/* File: hw/selftest_decode.sv */
`timescale 1ns/1ps
`default_nettype none
module selftest_decode
(
   input wire logic [3:0] code,
   input wire logic busy,
   input wire logic nsid_ok,
   output var selftest_pkg::act_t act
);
   import selftest_pkg::*;
   // ----------------------------------------
   // Action from code and in-progress state
   // ----------------------------------------
   always_comb
   begin
      act = ACT_INVALID;
      case (code)
         CODE_SHORT, CODE_EXT, CODE_VENDOR:
         begin
            if (busy)
               act = ACT_REJECT;
            else if (nsid_ok)
               act = ACT_START;
            else
               act = ACT_INVALID;
         end
         CODE_ABORT:
         begin
            if (busy)
               act = ACT_ABORT;
            else
               act = ACT_NOP_OK;
         end
         default:
            act = ACT_INVALID;
      endcase
   end
endmodule : selftest_decode
`default_nettype wire

/* File: hw/selftest_handler.sv */
`timescale 1ns/1ps
`default_nettype none
module selftest_handler
#(
   parameter int unsigned SHORT_CYCLES = 5000,
   parameter int unsigned EXT_CYCLES = 50000
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic subsys_test_busy,
   output logic test_running,
   output logic cpl_valid,
   output logic [7:0] cpl_status,
   output logic [2:0] cpl_type
);
   import selftest_pkg::*;

   test_engine_if eif ();
   state_t state_q;
   act_t act;
   act_t act_q;
   logic [3:0] code_q;
   logic [31:0] nsid_q;
   logic scope_q;
   logic [3:0] cur_status_q;
   logic [3:0] newest_code_q;
   logic [3:0] newest_res_q;
   logic newest_valid_q;
   logic cpl_valid_q;
   logic [7:0] cpl_status_q;
   logic [2:0] cpl_type_q;
   logic [31:0] prdata_q;
   logic [31:0] rdata;
   logic addr_ok;
   logic wr_en;
   logic rd_setup;
   logic busy;
   logic nsid_ok;
   logic submit;
   logic cpl_ack;

   // ----------------------------------------
   // APB decode
   // ----------------------------------------
   assign wr_en = psel & penable & pwrite & addr_ok;
   assign rd_setup = psel & ~penable & ~pwrite;
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~addr_ok;
   assign submit = wr_en && (paddr == ADDR_SUBMIT) && (state_q == ST_IDLE) && !cpl_valid_q;
   assign cpl_ack = wr_en && (paddr == ADDR_CPL);

   always_comb
   begin
      addr_ok = 1'b1;
      rdata = '0;
      if (paddr == ADDR_CMD_CODE)
         rdata[CODE_LSB +: 4] = code_q;
      else if (paddr == ADDR_CMD_NSID)
         rdata = nsid_q;
      else if (paddr == ADDR_CTRL)
         rdata[SCOPE_BIT] = scope_q;
      else if (paddr == ADDR_SUBMIT)
         rdata = '0;
      else if (paddr == ADDR_STATUS)
      begin
         rdata[STAT_CUR_LSB +: 4] = cur_status_q;
         rdata[STAT_RUN_BIT] = eif.running;
         rdata[STAT_BUSY_BIT] = (state_q != ST_IDLE);
         rdata[STAT_CPL_BIT] = cpl_valid_q;
      end
      else if (paddr == ADDR_CPL)
      begin
         rdata[CPL_SC_LSB +: 8] = cpl_status_q;
         rdata[CPL_SCT_LSB +: 3] = cpl_type_q;
         rdata[CPL_VALID_BIT] = cpl_valid_q;
      end
      else if (paddr == ADDR_LOG)
      begin
         rdata[LOG_RES_LSB +: 4] = newest_res_q;
         rdata[LOG_CODE_LSB +: 4] = newest_code_q;
         rdata[LOG_VALID_BIT] = newest_valid_q;
      end
      else
         addr_ok = 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata_q <= '0;
      else if (rd_setup)
         prdata_q <= rdata;
   end

   assign prdata = prdata_q;

   // ----------------------------------------
   // Command registers
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         code_q <= '0;
         nsid_q <= '0;
         scope_q <= 1'b0;
      end
      else if (wr_en && state_q == ST_IDLE)
      begin
         if (paddr == ADDR_CMD_CODE)
            code_q <= pwdata[CODE_LSB +: 4];
         else if (paddr == ADDR_CMD_NSID)
            nsid_q <= pwdata;
         else if (paddr == ADDR_CTRL)
            scope_q <= pwdata[SCOPE_BIT];
      end
   end

   // ----------------------------------------
   // Decision inputs
   // ----------------------------------------
   assign busy = scope_q ? (eif.running | subsys_test_busy) : eif.running;
   assign nsid_ok = (nsid_q == NSID_NONE) || (nsid_q == NSID_ALL) || (nsid_q <= NS_COUNT);

   selftest_decode u_decode (
      .code (code_q),
      .busy (busy),
      .nsid_ok (nsid_ok),
      .act (act)
   );

   test_engine #(
      .SHORT_CYCLES (SHORT_CYCLES),
      .EXT_CYCLES (EXT_CYCLES)
   ) u_engine (
      .clk (pclk),
      .rst_n (presetn),
      .eif (eif.eng)
   );

   assign eif.start = (state_q == ST_START);
   assign eif.abort = (state_q == ST_STOP);
   assign eif.extended = (code_q == CODE_EXT);
   assign test_running = eif.running;

   // ----------------------------------------
   // Command sequencer
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_q <= ST_IDLE;
         act_q <= ACT_INVALID;
      end
      else
      begin
         case (state_q)
            ST_IDLE:
               if (submit)
                  state_q <= ST_DECODE;
            ST_DECODE:
            begin
               act_q <= act;
               if (act == ACT_ABORT)
                  state_q <= ST_STOP;
               else if (act == ACT_START)
                  state_q <= ST_STATUS;
               else
                  state_q <= ST_POST;
            end
            ST_STOP:
               state_q <= ST_LOG;
            ST_LOG:
               state_q <= ST_STATUS;
            ST_STATUS:
               state_q <= (act_q == ACT_ABORT) ? ST_POST : ST_START;
            ST_START:
               state_q <= ST_POST;
            ST_POST:
               state_q <= ST_WAIT;
            ST_WAIT:
               if (!cpl_valid_q)
                  state_q <= ST_IDLE;
            default:
               state_q <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // Self-test log
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cur_status_q <= TS_IDLE;
         newest_code_q <= '0;
         newest_res_q <= '0;
         newest_valid_q <= 1'b0;
      end
      else if (state_q == ST_LOG)
      begin
         newest_code_q <= cur_status_q;
         newest_res_q <= RES_ABORTED;
         newest_valid_q <= 1'b1;
      end
      else if (state_q == ST_STATUS)
         cur_status_q <= (act_q == ACT_ABORT) ? TS_IDLE : code_q;
      else if (eif.done)
      begin
         newest_code_q <= cur_status_q;
         newest_res_q <= RES_OK;
         newest_valid_q <= 1'b1;
         cur_status_q <= TS_IDLE;
      end
   end

   // ----------------------------------------
   // Completion entry
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cpl_valid_q <= 1'b0;
         cpl_status_q <= SC_SUCCESS;
         cpl_type_q <= SCT_GENERIC;
      end
      else if (state_q == ST_POST)
      begin
         cpl_valid_q <= 1'b1;
         if (act_q == ACT_REJECT)
         begin
            cpl_status_q <= SC_IN_PROGRESS;
            cpl_type_q <= SCT_CMD;
         end
         else if (act_q == ACT_INVALID)
         begin
            cpl_status_q <= SC_INVALID_FIELD;
            cpl_type_q <= SCT_GENERIC;
         end
         else
         begin
            cpl_status_q <= SC_SUCCESS;
            cpl_type_q <= SCT_GENERIC;
         end
      end
      else if (cpl_ack)
         cpl_valid_q <= 1'b0;
   end

   assign cpl_valid = cpl_valid_q;
   assign cpl_status = cpl_status_q;
   assign cpl_type = cpl_type_q;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_ok_post;
      cpl_valid_q && cpl_status_q == SC_SUCCESS && cpl_type_q == SCT_GENERIC;
   endsequence
   sequence s_abort_steps;
      state_q == ST_STOP ##1 state_q == ST_LOG ##1 state_q == ST_STATUS ##1 state_q == ST_POST;
   endsequence
   sequence s_start_steps(logic [3:0] c);
      state_q == ST_STATUS ##1 (state_q == ST_START && cur_status_q == c) ##1 eif.running;
   endsequence

   property p_busy_reject;
      state_q == ST_DECODE && busy && (code_q == CODE_SHORT || code_q == CODE_EXT)
         |-> ##2 cpl_valid_q && cpl_status_q == SC_IN_PROGRESS && cpl_type_q == SCT_CMD;
   endproperty
   a_busy_reject: assert property (p_busy_reject) else $error("busy request not rejected");

   property p_abort_run;
      state_q == ST_DECODE && busy && code_q == CODE_ABORT
         |-> ##1 s_abort_steps ##0 (!eif.running && cur_status_q == TS_IDLE && newest_res_q == RES_ABORTED)
         ##1 s_ok_post;
   endproperty
   a_abort_run: assert property (p_abort_run) else $error("abort sequence wrong");

   property p_start_short;
      state_q == ST_DECODE && !busy && nsid_ok && code_q == CODE_SHORT
         |-> ##1 s_start_steps(CODE_SHORT) ##1 s_ok_post;
   endproperty
   a_start_short: assert property (p_start_short) else $error("short start wrong");

   property p_start_ext;
      state_q == ST_DECODE && !busy && nsid_ok && code_q == CODE_EXT
         |-> ##1 s_start_steps(CODE_EXT) ##1 s_ok_post;
   endproperty
   a_start_ext: assert property (p_start_ext) else $error("extended start wrong");

   property p_abort_idle;
      state_q == ST_DECODE && !busy && code_q == CODE_ABORT
         |-> ##1 ($stable(cur_status_q) && $stable(newest_code_q) && $stable(newest_res_q)
         && $stable(newest_valid_q)) [*2]
         ##0 s_ok_post;
   endproperty
   a_abort_idle: assert property (p_abort_idle) else $error("idle abort touched log");

   property p_scope_local;
      state_q == ST_DECODE && !scope_q && subsys_test_busy && !eif.running && nsid_ok && code_q == CODE_SHORT
         |-> ##4 s_ok_post;
   endproperty
   a_scope_local: assert property (p_scope_local) else $error("local scope saw subsystem");

   property p_post_after;
      $rose(cpl_valid_q) |-> $past(state_q) == ST_POST && $past(state_q, 2) != ST_DECODE | act_q != ACT_START;
   endproperty
   a_post_after: assert property (p_post_after) else $error("completion posted early");

   property p_nsid_all;
      state_q == ST_DECODE && !busy && nsid_q == NSID_ALL && code_q == CODE_EXT |-> ##4 s_ok_post;
   endproperty
   a_nsid_all: assert property (p_nsid_all) else $error("all namespace id refused");

   property p_invalid;
      state_q == ST_DECODE && (code_q == TS_IDLE || (!busy && !nsid_ok && code_q == CODE_SHORT))
         |-> ##1 ($stable(cur_status_q) && state_q == ST_POST) ##1 ($stable(cur_status_q)
         && cpl_valid_q && cpl_status_q == SC_INVALID_FIELD);
   endproperty
   a_invalid: assert property (p_invalid) else $error("invalid field not reported");

   property p_vendor;
      state_q == ST_DECODE && !busy && nsid_ok && code_q == CODE_VENDOR |-> ##2 cur_status_q == CODE_VENDOR;
   endproperty
   a_vendor: assert property (p_vendor) else $error("vendor test not started");
endmodule : selftest_handler
`default_nettype wire

/* File: hw/selftest_pkg.sv */
`default_nettype none
package selftest_pkg;
   // ----------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] ADDR_CMD_CODE = 8'h00;
   localparam logic [7:0] ADDR_CMD_NSID = 8'h04;
   localparam logic [7:0] ADDR_CTRL = 8'h08;
   localparam logic [7:0] ADDR_SUBMIT = 8'h0C;
   localparam logic [7:0] ADDR_STATUS = 8'h10;
   localparam logic [7:0] ADDR_CPL = 8'h14;
   localparam logic [7:0] ADDR_LOG = 8'h18;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int CODE_LSB = 0;
   localparam int SCOPE_BIT = 0;
   localparam int STAT_CUR_LSB = 0;
   localparam int STAT_RUN_BIT = 4;
   localparam int STAT_BUSY_BIT = 5;
   localparam int STAT_CPL_BIT = 6;
   localparam int CPL_SC_LSB = 0;
   localparam int CPL_SCT_LSB = 8;
   localparam int CPL_VALID_BIT = 16;
   localparam int LOG_RES_LSB = 0;
   localparam int LOG_CODE_LSB = 4;
   localparam int LOG_VALID_BIT = 8;
   // ----------------------------------------
   // Test action codes and status values
   // ----------------------------------------
   localparam logic [3:0] CODE_SHORT = 4'h1;
   localparam logic [3:0] CODE_EXT = 4'h2;
   localparam logic [3:0] CODE_VENDOR = 4'hE;
   localparam logic [3:0] CODE_ABORT = 4'hF;
   localparam logic [3:0] TS_IDLE = 4'h0;
   localparam logic [3:0] RES_OK = 4'h0;
   localparam logic [3:0] RES_ABORTED = 4'h1;
   localparam logic [7:0] SC_SUCCESS = 8'h00;
   localparam logic [7:0] SC_INVALID_FIELD = 8'h02;
   localparam logic [7:0] SC_IN_PROGRESS = 8'h1D;
   localparam logic [2:0] SCT_GENERIC = 3'h0;
   localparam logic [2:0] SCT_CMD = 3'h1;
   localparam logic [31:0] NSID_NONE = 32'h0000_0000;
   localparam logic [31:0] NSID_ALL = 32'hFFFF_FFFF;
   localparam logic [31:0] NS_COUNT = 32'h0000_0004;
   localparam int CNT_W = 24;
   typedef logic [CNT_W-1:0] cnt_t;
   typedef enum logic [2:0] {
      ACT_REJECT = 3'b000,
      ACT_ABORT = 3'b001,
      ACT_NOP_OK = 3'b010,
      ACT_START = 3'b011,
      ACT_INVALID = 3'b100
   } act_t;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_DECODE = 3'b001,
      ST_STOP = 3'b010,
      ST_LOG = 3'b011,
      ST_STATUS = 3'b100,
      ST_START = 3'b101,
      ST_POST = 3'b110,
      ST_WAIT = 3'b111
   } state_t;
endpackage : selftest_pkg
`default_nettype wire

/* File: hw/test_engine.sv */
`timescale 1ns/1ps
`default_nettype none
module test_engine
   import selftest_pkg::*;
#(
   parameter int unsigned SHORT_CYCLES = 5000,
   parameter int unsigned EXT_CYCLES = 50000
)
(
   input wire logic clk,
   input wire logic rst_n,
   test_engine_if.eng eif
);
   cnt_t cnt_q;
   logic running_q;
   logic done_q;

   // ----------------------------------------
   // Test run timer
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         running_q <= 1'b0;
         cnt_q <= '0;
         done_q <= 1'b0;
      end
      else
      begin
         done_q <= 1'b0;
         if (eif.abort)
            running_q <= 1'b0;
         else if (eif.start)
         begin
            running_q <= 1'b1;
            cnt_q <= eif.extended ? cnt_t'(EXT_CYCLES - 1) : cnt_t'(SHORT_CYCLES - 1);
         end
         else if (running_q)
         begin
            if (cnt_q == '0)
            begin
               running_q <= 1'b0;
               done_q <= 1'b1;
            end
            else
               cnt_q <= cnt_q - cnt_t'(1);
         end
      end
   end

   assign eif.running = running_q;
   assign eif.done = done_q;
endmodule : test_engine
`default_nettype wire

/* File: hw/test_engine_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface test_engine_if;
   logic start;
   logic abort;
   logic extended;
   logic running;
   logic done;
   modport ctl (output start, output abort, output extended, input running, input done);
   modport eng (input start, input abort, input extended, output running, output done);
endinterface : test_engine_if
`default_nettype wire

/* File: tb/subsys_test_model.sv */
`timescale 1ns/1ps
`default_nettype none
module subsys_test_model
#(
   parameter int unsigned RUN_CYCLES = 200
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic go,
   output logic busy
);
   int unsigned cnt_q;
   // ----------------------------------------
   // Test run on another controller
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_q <= 0;
      end
      else if (go)
      begin
         cnt_q <= RUN_CYCLES;
      end
      else if (cnt_q != 0)
      begin
         cnt_q <= cnt_q - 1;
      end
   end
   assign busy = (cnt_q != 0);
endmodule : subsys_test_model
`default_nettype wire

/* File: tb/test_self_test_command_handler.sv */
`timescale 1ns/1ps
`default_nettype none
module test_self_test_command_handler;
   import selftest_pkg::*;
   localparam int unsigned SHORT_N = 200;
   localparam int unsigned EXT_N = 300;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic subsys_test_busy, test_running, cpl_valid, sub_go;
   logic [7:0] paddr, cpl_status;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0] cpl_type;
   logic [3:0] rsv_codes [3];
   int n_mismatch, checks_done;
   // ----------------------------------------
   // Design and far side
   // ----------------------------------------
   selftest_handler #(.SHORT_CYCLES(SHORT_N), .EXT_CYCLES(EXT_N)) u_dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .subsys_test_busy(subsys_test_busy), .test_running(test_running),
      .cpl_valid(cpl_valid), .cpl_status(cpl_status), .cpl_type(cpl_type));
   subsys_test_model #(.RUN_CYCLES(200)) u_sub (.clk(pclk), .rst_n(presetn), .go(sub_go),
      .busy(subsys_test_busy));
   initial
   begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task give_verdict;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
      begin
         $display("STATUS OK");
      end
      else
      begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : give_verdict
   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do
      begin
         @(posedge pclk);
         i++;
      end
      while (pready !== 1'b1 && i < 50);
      if (i >= 50)
      begin
         n_mismatch++;
         give_verdict();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task run_cmd(input logic [3:0] code, input logic [31:0] ns, input logic scope, input logic [7:0] sc,
      input logic [2:0] sct);
      int i;
      apb(1'b1, ADDR_CMD_CODE, {28'h0, code});
      apb(1'b1, ADDR_CMD_NSID, ns);
      apb(1'b1, ADDR_CTRL, {31'h0, scope});
      apb(1'b1, ADDR_SUBMIT, 32'h1);
      i = 0;
      do
      begin
         apb(1'b0, ADDR_CPL, 32'h0);
         i++;
      end
      while (rd[CPL_VALID_BIT] !== 1'b1 && i < 20);
      if (i >= 20)
      begin
         n_mismatch++;
         give_verdict();
      end
      check("cpl entry", rd, {15'h0, 1'b1, 5'h0, sct, sc});
      check("cpl pins", {20'h0, cpl_valid, cpl_type, cpl_status}, {20'h0, 1'b1, sct, sc});
      apb(1'b1, ADDR_CPL, 32'h0);
      repeat (3) @(posedge pclk);
   endtask : run_cmd
   task wait_idle;
      int i;
      i = 0;
      do
      begin
         apb(1'b0, ADDR_STATUS, 32'h0);
         i++;
      end
      while (rd[STAT_RUN_BIT] !== 1'b0 && i < 400);
      if (i >= 400)
      begin
         n_mismatch++;
         give_verdict();
      end
   endtask : wait_idle
   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      sub_go = 1'b0;
      n_mismatch = 0;
      checks_done = 0;
      rsv_codes = '{4'h0, 4'h3, 4'hD};
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, ADDR_STATUS, 32'h0);
      check("status reset", rd, 32'h0);
      apb(1'b0, ADDR_LOG, 32'h0);
      check("log reset", rd, 32'h0);
      apb(1'b0, 8'h1C, 32'h0);
      check("unmapped", {err, rd[30:0]}, 32'h8000_0000);
      foreach (rsv_codes[k])
      begin
         run_cmd(rsv_codes[k], NSID_NONE, 1'b0, SC_INVALID_FIELD, SCT_GENERIC);
      end
      run_cmd(CODE_SHORT, 32'h5, 1'b0, SC_INVALID_FIELD, SCT_GENERIC);
      apb(1'b0, ADDR_STATUS, 32'h0);
      check("status after invalid", rd[4:0], 32'h0);
      run_cmd(CODE_SHORT, NSID_ALL, 1'b0, SC_SUCCESS, SCT_GENERIC);
      check("running pin", test_running, 32'h1);
      apb(1'b0, ADDR_STATUS, 32'h0);
      check("status short", rd[4:0], 32'h11);
      run_cmd(CODE_SHORT, NSID_NONE, 1'b0, SC_IN_PROGRESS, SCT_CMD);
      run_cmd(CODE_EXT, NSID_NONE, 1'b0, SC_IN_PROGRESS, SCT_CMD);
      run_cmd(CODE_VENDOR, NSID_NONE, 1'b0, SC_IN_PROGRESS, SCT_CMD);
      apb(1'b0, ADDR_STATUS, 32'h0);
      check("status kept", rd[4:0], 32'h11);
      run_cmd(CODE_ABORT, NSID_NONE, 1'b0, SC_SUCCESS, SCT_GENERIC);
      check("stopped pin", test_running, 32'h0);
      apb(1'b0, ADDR_STATUS, 32'h0);
      check("status aborted", rd[4:0], 32'h0);
      apb(1'b0, ADDR_LOG, 32'h0);
      check("log aborted", rd, 32'h111);
      run_cmd(CODE_EXT, NSID_NONE, 1'b0, SC_SUCCESS, SCT_GENERIC);
      apb(1'b0, ADDR_STATUS, 32'h0);
      check("status ext", rd[4:0], 32'h12);
      wait_idle();
      apb(1'b0, ADDR_LOG, 32'h0);
      check("log ext", rd, 32'h120);
      run_cmd(CODE_VENDOR, 32'h4, 1'b0, SC_SUCCESS, SCT_GENERIC);
      apb(1'b0, ADDR_STATUS, 32'h0);
      check("status vendor", rd[4:0], 32'h1E);
      wait_idle();
      apb(1'b0, ADDR_STATUS, 32'h0);
      check("status done", rd[3:0], 32'h0);
      apb(1'b0, ADDR_LOG, 32'h0);
      check("log vendor", rd, 32'h1E0);
      run_cmd(CODE_ABORT, NSID_NONE, 1'b0, SC_SUCCESS, SCT_GENERIC);
      apb(1'b0, ADDR_LOG, 32'h0);
      check("log untouched", rd, 32'h1E0);
      sub_go <= 1'b1;
      @(posedge pclk);
      sub_go <= 1'b0;
      run_cmd(CODE_SHORT, NSID_NONE, 1'b1, SC_IN_PROGRESS, SCT_CMD);
      run_cmd(CODE_SHORT, NSID_NONE, 1'b0, SC_SUCCESS, SCT_GENERIC);
      run_cmd(CODE_ABORT, NSID_NONE, 1'b0, SC_SUCCESS, SCT_GENERIC);
      give_verdict();
   end
endmodule : test_self_test_command_handler
`default_nettype wire
